// ---- verilog/dpsc_pkg.sv ----
`default_nettype none
package dpsc_pkg;

  // register map of the controller, byte addresses on the control bus
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_WDATA = 8'h08;
  localparam logic [7:0] OFS_RDATA = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // control word fields
  localparam int CTRL_START = 0;
  localparam int CTRL_WRITE = 1;
  localparam int CTRL_FLAG = 2;
  localparam int CTRL_LOWER = 4;
  localparam int CTRL_UPPER = 5;

  // status word fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_ERR = 2;

  // memory port shape
  localparam int DQ_W = 18;
  localparam int LANE_W = 9;
  localparam int MEM_ADDR_W = 18;
  localparam int FLAG_SEL_W = 3;

  // values after reset
  localparam logic [1:0] RST_LANES = 2'h3;
  localparam logic [17:0] RST_WORD = 18'h00000;

  // phase lengths in core_clk cycles
  localparam int SETUP_CYC = 1;
  localparam int STROBE_CYC = 2;
  localparam int SYNC_CYC = 3;
  localparam int HOLD_CYC = 1;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SETUP = 3'h1,
    ST_STROBE = 3'h2,
    ST_SAMPLE = 3'h3,
    ST_HOLD = 3'h4
  } dpsc_state_e;

  // aligned word inside the map
  function automatic logic addr_mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= OFS_STATUS);
  endfunction

endpackage
`default_nettype wire

// ---- verilog/dpsc_reg_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface dpsc_reg_if;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;

  modport bus_end (output wr_en, output wr_addr, output wr_data, output wr_strb, output rd_addr, input rd_data);
  modport regs_end (input wr_en, input wr_addr, input wr_data, input wr_strb, input rd_addr, output rd_data);
endinterface
`default_nettype wire

// ---- verilog/dpsc_axil_slave.sv ----
`timescale 1ns/1ns
`default_nettype none
module dpsc_axil_slave (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // write channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // register side
  dpsc_reg_if.bus_end regs
);

  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [7:0] ar_addr;
  logic rd_pend;

  // the write fires once, in the cycle both halves are held and no answer is out yet
  assign regs.wr_en = !s_axi_awready && !s_axi_wready && !s_axi_bvalid && dpsc_pkg::addr_mapped(aw_addr);
  assign regs.wr_addr = aw_addr;
  assign regs.wr_data = w_data;
  assign regs.wr_strb = w_strb;
  assign regs.rd_addr = ar_addr;

  // write path: address and data taken in either order, one write at a time
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= dpsc_pkg::RESP_OKAY;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= dpsc_pkg::addr_mapped(aw_addr) ? dpsc_pkg::RESP_OKAY : dpsc_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // read path: the address is registered so the register mux settles for a full cycle
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= dpsc_pkg::RESP_OKAY;
      ar_addr <= 8'h00;
      rd_pend <= 1'b0;
    end else begin
      rd_pend <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
        ar_addr <= s_axi_araddr;
        s_axi_arready <= 1'b0;
        rd_pend <= 1'b1;
      end
      if (rd_pend) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= dpsc_pkg::addr_mapped(ar_addr) ? regs.rd_data : 32'h00000000;
        s_axi_rresp <= dpsc_pkg::addr_mapped(ar_addr) ? dpsc_pkg::RESP_OKAY : dpsc_pkg::RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ---- verilog/dpsc_ctrl.sv ----
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - lower-lane write: lower select only, upper data lines left undriven
// - upper-lane write: upper select only, lower data lines left undriven
// - flag write: chip off, flag access on, strobe and lower select, bit 0 driven
// - flag read: chip off, flag access on, strobe high, output enable on
// - flag read needs at least one lane select active to see data
module dpsc_ctrl #(
  parameter int SETUP_CYC = dpsc_pkg::SETUP_CYC,
  parameter int STROBE_CYC = dpsc_pkg::STROBE_CYC,
  parameter int SYNC_CYC = dpsc_pkg::SYNC_CYC,
  parameter int HOLD_CYC = dpsc_pkg::HOLD_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // control bus, write channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // control bus, read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // memory port controls
  output logic chip_select_active_low_n,
  output logic chip_select_active_high,
  output logic flag_access_select_n,
  output logic read_not_write,
  output logic output_enable_n,
  output logic upper_lane_select_n,
  output logic lower_lane_select_n,
  output logic [17:0] mem_addr,
  // memory port data lines
  input wire logic [17:0] dq_in,
  output logic [17:0] dq_out,
  output logic [17:0] dq_oe
);

  dpsc_reg_if regs();

  dpsc_axil_slave u_slave (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .regs(regs.bus_end)
  );

  // byte-enable merge, shared by the control, address and write data registers
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  logic op_write;
  logic op_flag;
  logic lane_upper;
  logic lane_lower;
  logic [17:0] addr_word;
  logic [17:0] wr_word;
  logic [17:0] rd_word;
  logic busy;
  logic done;
  logic err;
  dpsc_pkg::dpsc_state_e state;
  logic [7:0] cnt;
  logic [17:0] dq_s1;
  logic [17:0] dq_s2;
  logic [17:0] dq_s3;
  logic wr_ctrl;
  logic wr_addr_reg;
  logic wr_wdata_reg;
  logic wr_status;
  logic [31:0] ctrl_new;
  logic start_req;
  logic req_ok;
  logic eff_lower;
  logic eff_upper;
  logic phase_end;
  logic capture;
  logic finish;
  logic flag_bit;

  // register write decode and the control word as it will be after this write
  always_comb begin
    wr_ctrl = regs.wr_en && (regs.wr_addr == dpsc_pkg::OFS_CTRL);
    wr_addr_reg = regs.wr_en && (regs.wr_addr == dpsc_pkg::OFS_ADDR);
    wr_wdata_reg = regs.wr_en && (regs.wr_addr == dpsc_pkg::OFS_WDATA);
    wr_status = regs.wr_en && (regs.wr_addr == dpsc_pkg::OFS_STATUS);
    ctrl_new = merge_bytes({26'h0000000, lane_upper, lane_lower, 1'b0, op_flag, op_write, 1'b0},
                           regs.wr_data, regs.wr_strb);
    start_req = wr_ctrl && ctrl_new[dpsc_pkg::CTRL_START] && !busy;
  end

  // lanes actually selected for the request being started
  always_comb begin
    if (ctrl_new[dpsc_pkg::CTRL_FLAG] && ctrl_new[dpsc_pkg::CTRL_WRITE]) begin
      eff_lower = 1'b1;
      eff_upper = 1'b0;
    end else begin
      eff_lower = ctrl_new[dpsc_pkg::CTRL_LOWER];
      eff_upper = ctrl_new[dpsc_pkg::CTRL_UPPER];
    end
    // a request with no lane would move nothing, so it is refused
    req_ok = eff_lower || eff_upper;
  end

  // phase timing and the end-of-transfer events
  always_comb begin
    phase_end = 1'b0;
    case (state)
      dpsc_pkg::ST_SETUP: phase_end = (cnt == 8'(SETUP_CYC - 1));
      dpsc_pkg::ST_STROBE: phase_end = (cnt == 8'(STROBE_CYC - 1));
      dpsc_pkg::ST_SAMPLE: phase_end = (cnt >= 8'(SYNC_CYC - 1)) && (dq_s2 == dq_s3);
      dpsc_pkg::ST_HOLD: phase_end = (cnt == 8'(HOLD_CYC - 1));
      default: phase_end = 1'b0;
    endcase
    capture = (state == dpsc_pkg::ST_SAMPLE) && phase_end;
    finish = (state == dpsc_pkg::ST_HOLD) && phase_end;
    // the flag value is the same on every line, take it from whichever lane is on
    flag_bit = lane_lower ? dq_s3[0] : dq_s3[dpsc_pkg::LANE_W];
  end

  // three-stage synchroniser on the data lines; only stages two and three are compared
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dq_s1 <= dpsc_pkg::RST_WORD;
      dq_s2 <= dpsc_pkg::RST_WORD;
      dq_s3 <= dpsc_pkg::RST_WORD;
    end else begin
      dq_s1 <= dq_in;
      dq_s2 <= dq_s1;
      dq_s3 <= dq_s2;
    end
  end

  // software registers: request shape, address, write data
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      op_write <= 1'b0;
      op_flag <= 1'b0;
      lane_lower <= dpsc_pkg::RST_LANES[0];
      lane_upper <= dpsc_pkg::RST_LANES[1];
      addr_word <= dpsc_pkg::RST_WORD;
      wr_word <= dpsc_pkg::RST_WORD;
    end else begin
      // the request shape is frozen while a transfer is on the pins
      if (wr_ctrl && !busy) begin
        op_write <= ctrl_new[dpsc_pkg::CTRL_WRITE];
        op_flag <= ctrl_new[dpsc_pkg::CTRL_FLAG];
        lane_lower <= eff_lower;
        lane_upper <= eff_upper;
      end
      if (wr_addr_reg && !busy) begin
        addr_word <= 18'(merge_bytes({14'h0000, addr_word}, regs.wr_data, regs.wr_strb));
      end
      if (wr_wdata_reg && !busy) begin
        wr_word <= 18'(merge_bytes({14'h0000, wr_word}, regs.wr_data, regs.wr_strb));
      end
    end
  end

  // read data capture, masked to the lanes that were driven
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_word <= dpsc_pkg::RST_WORD;
    end else if (capture) begin
      if (op_flag) begin
        rd_word <= {17'h00000, flag_bit};
      end else begin
        rd_word <= dq_s3 & {{9{lane_upper}}, {9{lane_lower}}};
      end
    end
  end

  // status: busy, sticky done and error; a hardware set beats a write-one clear
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy <= 1'b0;
      done <= 1'b0;
      err <= 1'b0;
    end else begin
      if (start_req && req_ok) begin
        busy <= 1'b1;
      end else if (finish) begin
        busy <= 1'b0;
      end
      if (finish || (start_req && !req_ok)) begin
        done <= 1'b1;
      end else if (wr_status && regs.wr_strb[0] && regs.wr_data[dpsc_pkg::STAT_DONE]) begin
        done <= 1'b0;
      end
      if (start_req && !req_ok) begin
        err <= 1'b1;
      end else if (wr_status && regs.wr_strb[0] && regs.wr_data[dpsc_pkg::STAT_ERR]) begin
        err <= 1'b0;
      end
    end
  end

  // register read mux; reserved bits read as zero
  always_comb begin
    regs.rd_data = 32'h00000000;
    case (regs.rd_addr)
      dpsc_pkg::OFS_CTRL: regs.rd_data = {26'h0000000, lane_upper, lane_lower, 1'b0, op_flag, op_write, 1'b0};
      dpsc_pkg::OFS_ADDR: regs.rd_data = {14'h0000, addr_word};
      dpsc_pkg::OFS_WDATA: regs.rd_data = {14'h0000, wr_word};
      dpsc_pkg::OFS_RDATA: regs.rd_data = {14'h0000, rd_word};
      dpsc_pkg::OFS_STATUS: regs.rd_data = {29'h00000000, err, done, busy};
      default: regs.rd_data = 32'h00000000;
    endcase
  end

  // transfer sequencer; every pin is a flip-flop so nothing glitches at the memory
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= dpsc_pkg::ST_IDLE;
      cnt <= 8'h00;
      chip_select_active_low_n <= 1'b1;
      chip_select_active_high <= 1'b0;
      flag_access_select_n <= 1'b1;
      read_not_write <= 1'b1;
      output_enable_n <= 1'b1;
      upper_lane_select_n <= 1'b1;
      lower_lane_select_n <= 1'b1;
      mem_addr <= dpsc_pkg::RST_WORD;
      dq_out <= dpsc_pkg::RST_WORD;
      dq_oe <= dpsc_pkg::RST_WORD;
    end else begin
      cnt <= phase_end ? 8'h00 : cnt + 8'h01;
      case (state)
        dpsc_pkg::ST_IDLE: begin
          cnt <= 8'h00;
          if (start_req && req_ok) begin
            state <= dpsc_pkg::ST_SETUP;
            if (ctrl_new[dpsc_pkg::CTRL_FLAG]) begin
              // chip enable held off for the whole flag access, never both at once
              chip_select_active_low_n <= 1'b1;
              chip_select_active_high <= 1'b0;
              flag_access_select_n <= 1'b0;
              mem_addr <= {15'h0000, addr_word[dpsc_pkg::FLAG_SEL_W-1:0]};
              dq_out <= {17'h00000, wr_word[0]};
            end else begin
              chip_select_active_low_n <= 1'b0;
              chip_select_active_high <= 1'b1;
              flag_access_select_n <= 1'b1;
              mem_addr <= addr_word;
              dq_out <= wr_word;
            end
            lower_lane_select_n <= !eff_lower;
            upper_lane_select_n <= !eff_upper;
            // only selected lanes are driven; reads leave the lines to the memory
            if (ctrl_new[dpsc_pkg::CTRL_WRITE]) begin
              dq_oe <= {{9{eff_upper}}, {9{eff_lower}}};
            end else begin
              dq_oe <= dpsc_pkg::RST_WORD;
            end
          end
        end
        dpsc_pkg::ST_SETUP: begin
          if (phase_end) begin
            state <= dpsc_pkg::ST_STROBE;
            if (op_write) begin
              read_not_write <= 1'b0;
            end else begin
              output_enable_n <= 1'b0;
            end
          end
        end
        dpsc_pkg::ST_STROBE: begin
          if (phase_end) begin
            if (op_write) begin
              // strobe ends while data is still driven, giving hold time
              read_not_write <= 1'b1;
              state <= dpsc_pkg::ST_HOLD;
            end else begin
              state <= dpsc_pkg::ST_SAMPLE;
            end
          end
        end
        dpsc_pkg::ST_SAMPLE: begin
          // waits for stable lines; a line that never settles stalls here
          if (phase_end) begin
            output_enable_n <= 1'b1;
            state <= dpsc_pkg::ST_HOLD;
          end
        end
        dpsc_pkg::ST_HOLD: begin
          if (phase_end) begin
            chip_select_active_low_n <= 1'b1;
            chip_select_active_high <= 1'b0;
            flag_access_select_n <= 1'b1;
            upper_lane_select_n <= 1'b1;
            lower_lane_select_n <= 1'b1;
            dq_oe <= dpsc_pkg::RST_WORD;
            state <= dpsc_pkg::ST_IDLE;
          end
        end
        default: begin
          state <= dpsc_pkg::ST_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ---- tb/dpsc_mem_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module dpsc_mem_model (
  // control pins
  input wire logic chip_select_active_low_n,
  input wire logic chip_select_active_high,
  input wire logic flag_access_select_n,
  input wire logic read_not_write,
  input wire logic output_enable_n,
  input wire logic upper_lane_select_n,
  input wire logic lower_lane_select_n,
  input wire logic [17:0] mem_addr,
  // data lines
  input wire logic [17:0] dq_in,
  output logic [17:0] mq,
  output logic [17:0] moe
);
  logic [17:0] mem [0:262143];
  logic [7:0] flag = 8'hff;
  wire sel = !chip_select_active_low_n && chip_select_active_high;
  wire fa = !flag_access_select_n;
  wire [17:0] ln = {{9{!upper_lane_select_n}}, {9{!lower_lane_select_n}}};
  // unwritten words read as unknown, so a read before any write cannot pass
  wire [17:0] cur = mem[mem_addr];
  // stores at the end of the strobe, when the data lines are still driven
  always @(posedge read_not_write) begin
    if (sel && !fa)
      mem[mem_addr] = (dq_in & ln) | (cur & ~ln);
    else if (!sel && fa && !lower_lane_select_n)
      flag[mem_addr[2:0]] = dq_in[0];
  end
  // drives only the selected lanes; chip and flag access together drive nothing
  always @* begin
    moe = 18'h0;
    mq = 18'h0;
    if (read_not_write && !output_enable_n && sel && !fa) begin
      moe = ln;
      mq = cur;
    end else if (read_not_write && !output_enable_n && !sel && fa) begin
      moe = ln;
      mq = {18{flag[mem_addr[2:0]]}};
    end
  end
endmodule
`default_nettype wire

// ---- tb/dpsc_ctrl_chk.sv ----
`timescale 1ns/1ns
`default_nettype none
module dpsc_ctrl_chk (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // bus answer
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  // memory pins
  input wire logic chip_select_active_low_n,
  input wire logic chip_select_active_high,
  input wire logic flag_access_select_n,
  input wire logic read_not_write,
  input wire logic output_enable_n,
  input wire logic upper_lane_select_n,
  input wire logic lower_lane_select_n,
  input wire logic [17:0] mem_addr,
  input wire logic [17:0] dq_out,
  input wire logic [17:0] dq_oe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  wire cs_on = !chip_select_active_low_n && chip_select_active_high;
  wire fl_on = !flag_access_select_n;
  // strobe of the default length, then the hold cycle
  sequence s_strobe;
    !read_not_write [*2] ##1 read_not_write;
  endsequence
  sequence s_release;
    dq_oe == 18'h0 && read_not_write;
  endsequence
  a_sel_exclusive: assert property (!(cs_on && fl_on)) else $error("chip and flag access together");
  a_upper_float: assert property (
    cs_on && !read_not_write && upper_lane_select_n |-> dq_oe[17:9] == 9'h0) else $error("upper lane driven");
  a_lower_float: assert property (
    cs_on && !read_not_write && lower_lane_select_n |-> dq_oe[8:0] == 9'h0) else $error("lower lane driven");
  a_flag_write: assert property (
    fl_on && !read_not_write |-> !lower_lane_select_n && dq_oe[0] && dq_oe[17:9] == 9'h0)
    else $error("flag write shape");
  a_flag_addr: assert property (fl_on |-> mem_addr[17:3] == 15'h0) else $error("flag address high bits");
  a_flag_read: assert property (
    fl_on && !output_enable_n |-> read_not_write && !(upper_lane_select_n && lower_lane_select_n))
    else $error("flag read shape");
  a_read_idle: assert property (!output_enable_n |-> read_not_write && dq_oe == 18'h0)
    else $error("driving while device outputs");
  a_write_steps: assert property ($fell(read_not_write) |-> s_strobe ##1 s_release)
    else $error("write phases");
  a_data_held: assert property (
    $fell(read_not_write) |-> ($stable(dq_out) && dq_oe != 18'h0) [*3])
    else $error("write data moved");
  a_resp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
endmodule
bind dpsc_ctrl dpsc_ctrl_chk u_chk (.*);
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdv, seed = 32'h0000a449;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic chip_select_active_low_n, chip_select_active_high, flag_access_select_n, read_not_write;
  logic output_enable_n, upper_lane_select_n, lower_lane_select_n;
  logic [17:0] mem_addr, dq_in, dq_out, dq_oe, mq, moe, held = 18'h0;
  logic [1:0] bq[$];
  logic [65:0] rq[$];
  int n_fail = 0, check_count = 0, cyc = 0;

  dpsc_ctrl u_dut (.*);
  dpsc_mem_model u_mem (.*);

  initial forever #10 core_clk = ~core_clk;
  // a floating bit shows the inverse of its last driven level, so stale data cannot pass
  always @* for (int i = 0; i < 18; i++) dq_in[i] = dq_oe[i] ? dq_out[i] : moe[i] ? mq[i] : ~held[i];
  always @(dq_in) for (int i = 0; i < 18; i++) if (dq_oe[i] || moe[i]) held[i] = dq_in[i];

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] cw(input logic w, input logic f, input logic [1:0] ln);
    return (32'(w) << dpsc_pkg::CTRL_WRITE) | (32'(f) << dpsc_pkg::CTRL_FLAG) | (32'(ln) << dpsc_pkg::CTRL_LOWER);
  endfunction
  function automatic logic [17:0] lm(input logic [1:0] ln);
    return {{9{ln[1]}}, {9{ln[0]}}};
  endfunction

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic fail(input string s);
    n_fail++;
    $display("[FAIL] %0t %s", $time, s);
  endtask
  task automatic cmp_b(input logic [1:0] e);
    check_count++;
    if (s_axi_bresp !== e) fail("write response");
  endtask
  task automatic cmp_r(input logic [65:0] e);
    check_count++;
    if (s_axi_rresp !== e[65:64] || (s_axi_rdata & e[63:32]) !== e[31:0]) fail("read data");
  endtask

  // results are matched against the oldest note as they appear
  always @(posedge core_clk) begin
    if (s_axi_bvalid && s_axi_bready) cmp_b(bq.pop_front());
    if (s_axi_rvalid && s_axi_rready) cmp_r(rq.pop_front());
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fail("timeout");
      give_verdict();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!s_axi_bvalid) @(posedge core_clk);
    s_axi_bready <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1, input logic [1:0] r = 2'h0);
    rq.push_back({r, m, e & m});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge core_clk);
    rdv = s_axi_rdata;
    s_axi_rready <= 1'b0;
    @(posedge core_clk);
  endtask
  // one memory transfer, waited out on the sticky done flag, which is then cleared
  task automatic xfer(input logic [31:0] c);
    wr(dpsc_pkg::OFS_CTRL, c | 32'h1);
    rdv = 32'h0;
    while (!rdv[dpsc_pkg::STAT_DONE]) rd(dpsc_pkg::OFS_STATUS, 32'h0, 32'h0);
    wr(dpsc_pkg::OFS_STATUS, 32'h2);
  endtask

  initial begin
    logic [31:0] a, d0, d1;
    logic [17:0] e;
    logic [7:0] f;
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    rd(dpsc_pkg::OFS_CTRL, 32'h30, 32'h37);
    rd(dpsc_pkg::OFS_ADDR, 32'h0);
    rd(dpsc_pkg::OFS_STATUS, 32'h0, 32'h7);
    rd(8'h14, 32'h0, '1, 2'h2);
    rd(8'h01, 32'h0, '1, 2'h2);
    wr(8'h18, 32'h5, 2'h2);
    // byte strobes: only the low byte of the address word may change
    s_axi_wstrb <= 4'h1;
    wr(dpsc_pkg::OFS_ADDR, 32'h3ffff);
    s_axi_wstrb <= 4'hf;
    rd(dpsc_pkg::OFS_ADDR, 32'hff);
    $display("test registers done");
    // writes through each lane mix over a full word, then reads through every lane mix
    for (int k = 1; k < 4; k++) begin
      a = rnd();
      d0 = rnd();
      d1 = rnd();
      wr(dpsc_pkg::OFS_ADDR, a & 32'h3ffff);
      wr(dpsc_pkg::OFS_WDATA, d0);
      xfer(cw(1'b1, 1'b0, 2'h3));
      wr(dpsc_pkg::OFS_WDATA, d1);
      xfer(cw(1'b1, 1'b0, k[1:0]));
      e = (d1[17:0] & lm(k[1:0])) | (d0[17:0] & ~lm(k[1:0]));
      for (int r = 1; r < 4; r++) begin
        xfer(cw(1'b0, 1'b0, r[1:0]));
        rd(dpsc_pkg::OFS_RDATA, 32'(e & lm(r[1:0])));
      end
    end
    $display("test lanes done");
    // every flag, with junk above the index and above data bit 0
    for (int i = 0; i < 8; i++) begin
      a = rnd();
      d0 = rnd();
      f[i] = d0[0];
      wr(dpsc_pkg::OFS_ADDR, (a & 32'h3fff8) | 32'(i));
      wr(dpsc_pkg::OFS_WDATA, d0);
      xfer(cw(1'b1, 1'b1, 2'h0));
    end
    for (int i = 0; i < 8; i++) begin
      for (int r = 1; r < 4; r++) begin
        wr(dpsc_pkg::OFS_ADDR, 32'(i));
        xfer(cw(1'b0, 1'b1, r[1:0]));
        rd(dpsc_pkg::OFS_RDATA, 32'(f[i]));
      end
    end
    $display("test flags done");
    // a data transfer with no lane is refused and flags an error
    wr(dpsc_pkg::OFS_CTRL, cw(1'b1, 1'b0, 2'h0) | 32'h1);
    rd(dpsc_pkg::OFS_STATUS, 32'h6, 32'h7);
    wr(dpsc_pkg::OFS_STATUS, 32'h6);
    rd(dpsc_pkg::OFS_STATUS, 32'h0, 32'h7);
    $display("test refusal done");
    @(posedge core_clk);
    give_verdict();
  end
endmodule
`default_nettype wire
